//--- include/dpc_regs.svh
// constants for the dual channel converter control block
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

// result word width and width of the digitised input levels
`define DPC_RES_BITS        14
`define DPC_IN_BITS         16

// full scale of each differential input, millivolts
`define DPC_FULL_SCALE_MV   1250

// trigger edges with no serial clock edge between them
`define DPC_TRIG_NAP        3'h2
`define DPC_TRIG_SLEEP      3'h4

// serial clock edges per frame, first data edge, gap between words
`define DPC_FRAME_EDGES     6'h20
`define DPC_FIRST_DATA_EDGE 6'h03
`define DPC_GAP_EDGES       6'h02

// result fifo depth in sample pairs
`define DPC_FIFO_DEPTH      32

// reference settling time and the clock rate it is counted at
`define DPC_REF_SETTLE_US   2000
`define DPC_CLK_MHZ         40
`define DPC_REF_SETTLE_CYC  (`DPC_REF_SETTLE_US * `DPC_CLK_MHZ)

`endif

//--- include/dpc_pkg.sv
// types of the dual channel converter control block
package dpc_pkg;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_NAP,
        PWR_SLEEP,
        PWR_SLEEP_WAKE
    } dpc_power_type;

endpackage

//--- verilog/dpc_coder.sv
// two's complement coder with over-range clipping for one channel
`timescale 1ns/100ps
`include "dpc_regs.svh"

module dpc_coder #(
    parameter int RES_W = `DPC_RES_BITS,
    parameter int IN_W  = `DPC_IN_BITS
) (
    // input pair, levels in result lsb units
    input  wire logic signed [IN_W-1:0]  level_pos,
    input  wire logic signed [IN_W-1:0]  level_neg,
    // clipped result
    output logic             [RES_W-1:0] code
);

    localparam logic signed [IN_W:0] POS_MAX = (IN_W+1)'((1 <<< (RES_W-1)) - 1);
    localparam logic signed [IN_W:0] NEG_MIN = -(IN_W+1)'(1 <<< (RES_W-1));

    logic signed [IN_W:0] diff;

    always_comb begin
        // one extra bit so the difference never wraps
        diff = (IN_W+1)'(level_pos) - (IN_W+1)'(level_neg);
        if (diff > POS_MAX) begin
            code = {1'b0, {(RES_W-1){1'b1}}};
        end else if (diff < NEG_MIN) begin
            code = {1'b1, {(RES_W-1){1'b0}}};
        end else begin
            code = diff[RES_W-1:0];
        end
    end

endmodule // dpc_coder

//--- verilog/dpc_fifo.sv
// result fifo with registered read data
`timescale 1ns/100ps

module dpc_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [AW:0]      count_q, count_d;
    logic [WIDTH-1:0] rd_data_q, rd_data_d;
    logic             valid_q, valid_d;
    logic             push, pop;

    always_comb begin
        push     = in_valid && (count_q != (AW+1)'(DEPTH));
        pop      = out_ready && valid_q;
        wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d  = count_q + (AW+1)'(push) - (AW+1)'(pop);
        valid_d  = count_d != '0;
        // bypass keeps the head register true when writing into the head slot
        rd_data_d = (push && wr_ptr_q == rd_ptr_d) ? in_data : mem_q[rd_ptr_d];
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_q  <= '0;
            rd_ptr_q  <= '0;
            count_q   <= '0;
            rd_data_q <= '0;
            valid_q   <= 1'b0;
        end else begin
            wr_ptr_q  <= wr_ptr_d;
            rd_ptr_q  <= rd_ptr_d;
            count_q   <= count_d;
            rd_data_q <= rd_data_d;
            valid_q   <= valid_d;
        end
    end

    assign in_ready  = count_q != (AW+1)'(DEPTH);
    assign out_valid = valid_q;
    assign out_data  = rd_data_q;

endmodule // dpc_fifo

//--- verilog/dpc_top.sv
// dual channel converter: conversion start, power-down decoding, serial output
`timescale 1ns/100ps
`include "dpc_regs.svh"

module dpc_top #(
    parameter int RES_W         = `DPC_RES_BITS,
    parameter int IN_W          = `DPC_IN_BITS,
    parameter int FIFO_DEPTH    = `DPC_FIFO_DEPTH,
    parameter int SETTLE_CYCLES = `DPC_REF_SETTLE_CYC
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   arst_n,
    // serial port from the controller
    input  wire logic                   serial_clk,
    input  wire logic                   sample_trigger,
    output logic                        serial_out,
    output logic                        serial_out_oe,
    // digitised analog inputs, in result lsb units
    input  wire logic signed [IN_W-1:0] first_pair_positive,
    input  wire logic signed [IN_W-1:0] first_pair_negative,
    input  wire logic signed [IN_W-1:0] second_pair_positive,
    input  wire logic signed [IN_W-1:0] second_pair_negative,
    // power and status
    output logic                        ref_enable,
    output logic                        nap_active,
    output logic                        sleep_active,
    output logic                        ref_settled,
    output logic                        capture_ready
);

    localparam logic [5:0] W0_FIRST = `DPC_FIRST_DATA_EDGE;
    localparam logic [5:0] W0_LAST  = W0_FIRST + 6'(RES_W) - 6'h01;
    localparam logic [5:0] W1_FIRST = W0_LAST + `DPC_GAP_EDGES + 6'h01;
    localparam logic [5:0] W1_LAST  = W1_FIRST + 6'(RES_W) - 6'h01;
    localparam int         SW       = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE_END = SW'(SETTLE_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // edge detection on the serial port inputs

    logic sck_prev_q, trig_prev_q;
    logic sck_rise, trig_rise;

    always_comb begin
        sck_rise  = serial_clk && !sck_prev_q;
        trig_rise = sample_trigger && !trig_prev_q;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_prev_q  <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            sck_prev_q  <= serial_clk;
            trig_prev_q <= sample_trigger;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sampling and coding of both channels

    logic signed [IN_W-1:0] lvl_pos [2];
    logic signed [IN_W-1:0] lvl_neg [2];
    logic        [RES_W-1:0] code   [2];

    assign lvl_pos[0] = first_pair_positive;
    assign lvl_neg[0] = first_pair_negative;
    assign lvl_pos[1] = second_pair_positive;
    assign lvl_neg[1] = second_pair_negative;

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        dpc_coder #(
            .RES_W (RES_W),
            .IN_W  (IN_W)
        ) u_coder (
            .level_pos (lvl_pos[ch]),
            .level_neg (lvl_neg[ch]),
            .code      (code[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // result fifo between the sample and the frame that sends it

    logic                 sample_trigger_start;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic [2*RES_W-1:0]   fifo_out_data;

    // a full fifo stalls new conversions rather than losing a sample pair
    dpc_fifo #(
        .WIDTH (2*RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (sample_trigger_start),
        .in_ready  (fifo_in_ready),
        .in_data   ({code[0], code[1]}),
        .out_valid (fifo_out_valid),
        .out_ready (sample_trigger_start),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // power-down decoding

    dpc_pkg::dpc_power_type pwr_q, pwr_d;
    logic [2:0] trig_cnt_q, trig_cnt_d;

    always_comb begin
        trig_cnt_d = trig_cnt_q;
        if (sck_rise) begin
            trig_cnt_d = trig_rise ? 3'h1 : 3'h0;
        end else if (trig_rise && trig_cnt_q != `DPC_TRIG_SLEEP) begin
            trig_cnt_d = trig_cnt_q + 3'h1;
        end

        pwr_d = pwr_q;
        unique case (pwr_q)
            dpc_pkg::PWR_ACTIVE: begin
                if (trig_rise && trig_cnt_d == `DPC_TRIG_NAP) begin
                    pwr_d = dpc_pkg::PWR_NAP;
                end
            end
            dpc_pkg::PWR_NAP: begin
                if (sck_rise) begin
                    pwr_d = dpc_pkg::PWR_ACTIVE;
                end else if (trig_rise && trig_cnt_d == `DPC_TRIG_SLEEP) begin
                    pwr_d = dpc_pkg::PWR_SLEEP;
                end
            end
            dpc_pkg::PWR_SLEEP: begin
                // reference stays off until a nap request follows
                if (sck_rise) begin
                    pwr_d = dpc_pkg::PWR_SLEEP_WAKE;
                end
            end
            dpc_pkg::PWR_SLEEP_WAKE: begin
                if (trig_rise && trig_cnt_d == `DPC_TRIG_NAP) begin
                    pwr_d = dpc_pkg::PWR_NAP;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_q      <= dpc_pkg::PWR_ACTIVE;
            trig_cnt_q <= 3'h0;
        end else begin
            pwr_q      <= pwr_d;
            trig_cnt_q <= trig_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power outputs and reference settling

    logic            ref_en_q, ref_en_d;
    logic            nap_q, nap_d;
    logic            sleep_q, sleep_d;
    logic            settled_q, settled_d;
    logic [SW-1:0]   settle_cnt_q, settle_cnt_d;

    always_comb begin
        // reference is on in active and nap, off through the sleep exit
        ref_en_d = (pwr_d == dpc_pkg::PWR_ACTIVE) || (pwr_d == dpc_pkg::PWR_NAP);
        nap_d    = pwr_d == dpc_pkg::PWR_NAP;
        sleep_d  = (pwr_d == dpc_pkg::PWR_SLEEP) || (pwr_d == dpc_pkg::PWR_SLEEP_WAKE);
        // status only: conversions are not held back, the controller must wait
        if (!ref_en_d) begin
            settle_cnt_d = '0;
        end else if (settle_cnt_q != SETTLE_END) begin
            settle_cnt_d = settle_cnt_q + SW'(1);
        end else begin
            settle_cnt_d = settle_cnt_q;
        end
        settled_d = ref_en_d && (settle_cnt_d == SETTLE_END);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_en_q     <= 1'b1;
            nap_q        <= 1'b0;
            sleep_q      <= 1'b0;
            settled_q    <= 1'b0;
            settle_cnt_q <= '0;
        end else begin
            ref_en_q     <= ref_en_d;
            nap_q        <= nap_d;
            sleep_q      <= sleep_d;
            settled_q    <= settled_d;
            settle_cnt_q <= settle_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion frame and serial output

    logic             busy_q, busy_d;
    logic [5:0]       edge_cnt_q, edge_cnt_d;
    logic [5:0]       edge_no;
    logic [RES_W-1:0] word0_q, word0_d;
    logic [RES_W-1:0] word1_q, word1_d;
    logic             sdo_q, sdo_d;
    logic             sdo_oe_q, sdo_oe_d;
    logic             cap_rdy_q;

    always_comb begin
        // the trigger's duty cycle is irrelevant, only its rising edge counts
        sample_trigger_start = trig_rise && !busy_q && (pwr_q == dpc_pkg::PWR_ACTIVE)
                     && fifo_in_ready;
        busy_d     = busy_q;
        edge_cnt_d = edge_cnt_q;
        word0_d    = word0_q;
        word1_d    = word1_q;
        sdo_d      = sdo_q;
        sdo_oe_d   = sdo_oe_q;
        edge_no    = edge_cnt_q + 6'h01;

        if (sample_trigger_start) begin
            busy_d     = 1'b1;
            edge_cnt_d = 6'h00;
            // the pair sent now was sampled at the previous start
            if (fifo_out_valid) begin
                word0_d = fifo_out_data[2*RES_W-1:RES_W];
                word1_d = fifo_out_data[RES_W-1:0];
            end else begin
                word0_d = '0;
                word1_d = '0;
            end
        end else if (sck_rise && busy_q) begin
            edge_cnt_d = edge_no;
            if (edge_no == `DPC_FRAME_EDGES) begin
                busy_d = 1'b0;
            end
            if (edge_no >= W0_FIRST && edge_no <= W0_LAST) begin
                sdo_d    = word0_q[RES_W-1];
                sdo_oe_d = 1'b1;
                word0_d  = {word0_q[RES_W-2:0], 1'b0};
            end else if (edge_no >= W1_FIRST && edge_no <= W1_LAST) begin
                sdo_d    = word1_q[RES_W-1];
                sdo_oe_d = 1'b1;
                word1_d  = {word1_q[RES_W-2:0], 1'b0};
            end else begin
                sdo_d    = 1'b0;
                sdo_oe_d = 1'b0;
            end
        end else if (sck_rise) begin
            // no frame running: keep the pin released
            sdo_d    = 1'b0;
            sdo_oe_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q     <= 1'b0;
            edge_cnt_q <= 6'h00;
            word0_q    <= '0;
            word1_q    <= '0;
            sdo_q      <= 1'b0;
            sdo_oe_q   <= 1'b0;
            cap_rdy_q  <= 1'b0;
        end else begin
            busy_q     <= busy_d;
            edge_cnt_q <= edge_cnt_d;
            word0_q    <= word0_d;
            word1_q    <= word1_d;
            sdo_q      <= sdo_d;
            sdo_oe_q   <= sdo_oe_d;
            cap_rdy_q  <= fifo_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign serial_out    = sdo_q;
    assign serial_out_oe = sdo_oe_q;
    assign ref_enable    = ref_en_q;
    assign nap_active    = nap_q;
    assign sleep_active  = sleep_q;
    assign ref_settled   = settled_q;
    assign capture_ready = cap_rdy_q;

endmodule // dpc_top

//--- testbench/dpc_top_sva.sv
// assertion checker for the converter control block
`timescale 1ns/100ps
module dpc_top_sva #(
    parameter int SETTLE_CYCLES = 20
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // serial port
    input wire logic serial_clk,
    input wire logic sample_trigger,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    // power
    input wire logic ref_enable,
    input wire logic nap_active,
    input wire logic sleep_active,
    input wire logic ref_settled
);
    logic       sclk_q, trig_q, first_q, sclk_rise, trig_rise;
    logic [2:0] cnt_q, cnt_d;
    int         on_q, on_d;
    ////////////////////////////////////////////////////////////
    // mirror of the trigger edge count, saturating at four
    assign sclk_rise = serial_clk & ~sclk_q;
    assign trig_rise = sample_trigger & ~trig_q;
    always_comb begin
        cnt_d = cnt_q;
        if (sclk_rise)
            cnt_d = {2'h0, trig_rise};
        else if (trig_rise && cnt_q < 3'h4)
            cnt_d = cnt_q + 3'h1;
        on_d = ref_enable ? on_q + 1 : 0;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q  <= 1'b0;
            trig_q  <= 1'b0;
            first_q <= 1'b0;
            cnt_q   <= 3'h0;
            on_q    <= 0;
        end else begin
            sclk_q  <= serial_clk;
            trig_q  <= sample_trigger;
            first_q <= 1'b1;
            cnt_q   <= cnt_d;
            on_q    <= on_d;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_nap_req;
        trig_rise && !sclk_rise && cnt_q == 3'h1;
    endsequence
    sequence s_sleep_req;
        trig_rise && !sclk_rise && cnt_q == 3'h3;
    endsequence
    a_power_up: assert property (!first_q |-> ref_enable && !nap_active
        && !sleep_active && !serial_out_oe) else $error("bad state after reset");
    a_nap_entry: assert property (((!nap_active && !sleep_active) and s_nap_req)
        |=> nap_active && ref_enable) else $error("nap not entered");
    a_nap_ref: assert property (nap_active |-> ref_enable)
        else $error("reference off in nap");
    a_clk_wakes: assert property (sclk_rise |=> !nap_active)
        else $error("clock edge did not clear nap");
    a_sleep_entry: assert property ((nap_active and s_sleep_req)
        |=> sleep_active && !nap_active && !ref_enable) else $error("sleep not entered");
    a_sleep_hold: assert property (sleep_active && sclk_rise
        |=> sleep_active && !ref_enable) else $error("sleep left on clock alone");
    a_sleep_exit: assert property ((sleep_active and s_nap_req)
        |=> nap_active && !sleep_active && ref_enable) else $error("sleep exit failed");
    a_out_on_clk: assert property (!$stable({serial_out, serial_out_oe})
        |-> $past(sclk_rise) || $past(sclk_rise, 2)) else $error("output moved without clock");
    a_settle_wait: assert property (ref_settled |-> on_q + 2 >= SETTLE_CYCLES)
        else $error("settled too early");
    // the mirror count lags the reference by one edge when it is switched off
    a_settle_done: assert property (ref_enable && on_q > SETTLE_CYCLES + 2 |-> ref_settled)
        else $error("settled too late");
endmodule // dpc_top_sva

bind dpc_top dpc_top_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_dpc_top_sva (
    .ref_clk(ref_clk), .arst_n(arst_n), .serial_clk(serial_clk),
    .sample_trigger(sample_trigger), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .ref_enable(ref_enable), .nap_active(nap_active),
    .sleep_active(sleep_active), .ref_settled(ref_settled));

//--- testbench/dpc_host_model.sv
// serial port master model: drives the serial clock and the trigger
`timescale 1ns/100ps
module dpc_host_model (
    // clock
    input  wire logic ref_clk,
    // serial lines, both stand low between frames
    output logic      serial_clk,
    output logic      sample_trigger
);
    initial begin
        serial_clk     = 1'b0;
        sample_trigger = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // one clock wide pulse, the suggested form
    task automatic trig();
        @(posedge ref_clk) sample_trigger <= 1'b1;
        @(posedge ref_clk) sample_trigger <= 1'b0;
    endtask
    // a trigger after pulse trig_at never lands on a clock rise
    task automatic clocks(input int n, input int trig_at);
        for (int i = 1; i <= n; i++) begin
            @(posedge ref_clk) serial_clk <= 1'b1;
            @(posedge ref_clk) serial_clk <= 1'b0;
            if (i == trig_at)
                trig();
        end
    endtask
    // clock, then nap request; caller clocks on afterwards
    task automatic wake_sleep();
        clocks(1, 0);
        trig();
        trig();
    endtask
    task automatic settle(input int cyc);
        repeat (cyc) @(posedge ref_clk);
    endtask
endmodule // dpc_host_model

//--- testbench/testbench.sv
// self-checking testbench for the converter control block
`timescale 1ns/100ps
module testbench;
    logic               ref_clk, arst_n, serial_clk, sample_trigger, serial_out;
    logic               serial_out_oe, ref_enable, nap_active, sleep_active, ref_settled;
    logic               capture_ready;
    logic signed [15:0] first_pair_positive, first_pair_negative;
    logic signed [15:0] second_pair_positive, second_pair_negative;
    logic        [27:0] exp_q[$];
    logic        [27:0] prev_pair, acc;
    int                 n_errors, n_checks, nb, lows;
    logic               sclk_p, rise, rise_p;

    dpc_host_model i_dpc_host_model (
        .ref_clk(ref_clk), .serial_clk(serial_clk), .sample_trigger(sample_trigger));
    dpc_top #(.SETTLE_CYCLES(20)) i_dpc_top (
        .ref_clk(ref_clk), .arst_n(arst_n), .serial_clk(serial_clk),
        .sample_trigger(sample_trigger), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .first_pair_positive(first_pair_positive),
        .first_pair_negative(first_pair_negative),
        .second_pair_positive(second_pair_positive),
        .second_pair_negative(second_pair_negative), .ref_enable(ref_enable),
        .nap_active(nap_active), .sleep_active(sleep_active),
        .ref_settled(ref_settled), .capture_ready(capture_ready));

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [13:0] code(input logic signed [15:0] p, input logic signed [15:0] n);
        logic signed [16:0] d;
        d = p - n;
        if (d > 17'sh01fff)
            return 14'h1fff;
        if (d < -17'sh02000)
            return 14'h2000;
        return d[13:0];
    endfunction
    function automatic logic signed [15:0] rnd();
        return 16'($urandom % 32'd8001) - 16'sh0fa0;
    endfunction
    // levels held until the next start; samples are taken at the trigger
    task automatic start(input logic signed [15:0] a, b, c, d);
        @(posedge ref_clk);
        first_pair_positive  <= a;
        first_pair_negative  <= b;
        second_pair_positive <= c;
        second_pair_negative <= d;
        i_dpc_host_model.trig();
        exp_q.push_back(prev_pair);
        prev_pair = {code(a, b), code(c, d)};
    endtask
    task automatic pwr(input logic [2:0] e);
        repeat (2) @(posedge ref_clk);
        #1;
        check(28'({nap_active, ref_enable, sleep_active}), 28'(e));
    endtask
    ////////////////////////////////////////////////////////////
    // monitor: one bit per serial clock rise, taken once it has settled
    always @(posedge ref_clk) begin
        rise = serial_clk && !sclk_p;
        sclk_p = serial_clk;
        #1;
        if (rise_p) begin
            if (serial_out_oe === 1'b1) begin
                if (nb == 14)
                    check(28'(lows), 28'h2);
                acc = {acc[26:0], serial_out};
                nb++;
                lows = 0;
                if (nb == 28) begin
                    check(acc, exp_q.pop_front());
                    nb = 0;
                end
            end else
                lows++;
        end
        rise_p = rise;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("watchdog expired");
        close_out();
    end
    initial begin
        {arst_n, sclk_p, rise_p, nb, lows, n_errors, n_checks} = '0;
        {first_pair_positive, first_pair_negative} = '0;
        {second_pair_positive, second_pair_negative} = '0;
        prev_pair = 28'h0;
        acc = 28'h0;
        void'($urandom(12282));
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        check(28'({ref_enable, nap_active, sleep_active, serial_out_oe, capture_ready}),
              28'h11);
        $display("test reset done");
        start(16'sh2000, 16'sh0000, 16'sh0000, 16'sh2001);
        i_dpc_host_model.clocks(34, 0);
        start(16'sh1fff, 16'sh0000, 16'she000, 16'sh0000);
        i_dpc_host_model.clocks(34, 0);
        start(16'sh7000, 16'sh6fff, 16'sh8000, 16'sh8001);
        i_dpc_host_model.clocks(34, 0);
        for (int k = 0; k < 3; k++) begin
            start(rnd(), rnd(), rnd(), rnd());
            i_dpc_host_model.clocks(34, k == 1 ? 10 : 0);
        end
        $display("test frames done");
        start(rnd(), rnd(), rnd(), rnd());
        i_dpc_host_model.trig();
        pwr(3'b110);
        i_dpc_host_model.clocks(1, 0);
        pwr(3'b010);
        i_dpc_host_model.clocks(33, 0);
        start(rnd(), rnd(), rnd(), rnd());
        i_dpc_host_model.clocks(1, 0);
        i_dpc_host_model.trig();
        pwr(3'b010);
        i_dpc_host_model.clocks(33, 0);
        $display("test nap done");
        start(rnd(), rnd(), rnd(), rnd());
        repeat (3) i_dpc_host_model.trig();
        pwr(3'b001);
        i_dpc_host_model.wake_sleep();
        pwr(3'b110);
        check(28'(ref_settled), 28'h0);
        i_dpc_host_model.settle(25);
        #1;
        check(28'(ref_settled), 28'h1);
        i_dpc_host_model.clocks(34, 0);
        pwr(3'b010);
        start(rnd(), rnd(), rnd(), rnd());
        i_dpc_host_model.clocks(34, 0);
        repeat (4) @(posedge ref_clk);
        check(28'(exp_q.size()), 28'h0);
        check(28'(capture_ready), 28'h1);
        $display("test sleep done");
        close_out();
    end
endmodule // testbench
